/* File: core/analog_conditioner.sv */
// Purpose: One analog channel: offset, low-pass filter, deadband
// Assumes: All voltages signed in 0.01 V steps
// Notes:   Filter time is approximated by a power-of-two shift
`timescale 1ns/1ps
`include "drive_cmd_map.svh"
module analog_conditioner
    import drive_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Millisecond step
    input  wire logic        ms_tick,
    // Sample and settings
    input  wire logic [15:0] raw_sample,
    input  wire logic [15:0] offset,
    input  wire logic [15:0] deadband,
    input  wire logic [15:0] filter_time,
    // Conditioned value
    output logic      [15:0] conditioned
);
    cond_state_s st_r;
    cond_state_s st_nxt;

    // Shift from highest set bit; cheaper than a true divider
    function automatic logic [4:0] shift_of(input logic [15:0] t);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (t[i]) begin
                s = 5'(i + 1);
            end
        end
        return s;
    endfunction : shift_of

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic signed [24:0] x;
        logic signed [24:0] diff;
        logic signed [16:0] f;
        logic signed [16:0] db;
        logic signed [16:0] mag;
        logic signed [16:0] y;
        f      = '0;
        db     = '0;
        mag    = '0;
        y      = '0;
        st_nxt = st_r;
        x      = 25'(($signed({raw_sample[15], raw_sample}) - $signed({offset[15], offset})) <<< `FILT_FRAC);
        diff   = x - st_r.acc;
        if (filter_time == 16'h0000) begin
            st_nxt.acc = x;
        end else if (ms_tick) begin
            st_nxt.acc = st_r.acc + (diff >>> shift_of(filter_time));
        end
        f   = 17'(st_r.acc >>> `FILT_FRAC);
        db  = $signed({deadband[15], deadband});
        mag = f[16] ? -f : f;
        if (mag > db) begin
            y = f[16] ? f + db : f - db;
        end else begin
            y = 17'sh00000;
        end
        // Saturate to the register width
        if (y > 17'sh07FFF) begin
            st_nxt.cond = 16'h7FFF;
        end else if (y < -17'sh08000) begin
            st_nxt.cond = 16'h8000;
        end else begin
            st_nxt.cond = y[15:0];
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign conditioned = st_r.cond;
endmodule : analog_conditioner

/* File: core/drive_cmd_map.svh */
// Purpose: Offsets, fields, reset values and timing of the command path
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the package; definitions only
`ifndef DRIVE_CMD_MAP_SVH
`define DRIVE_CMD_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_RAW1      8'h00
`define OFS_COND1     8'h04
`define OFS_RAW2      8'h08
`define OFS_COND2     8'h0C
`define OFS_FILT1     8'h10
`define OFS_DB1       8'h14
`define OFS_OFF1      8'h18
`define OFS_FILT2     8'h1C
`define OFS_DB2       8'h20
`define OFS_OFF2      8'h24
`define OFS_SPD_FAC   8'h28
`define OFS_SPD_SRC   8'h2C
`define OFS_CLAMP_HI  8'h30
`define OFS_CLAMP_LO  8'h34
`define OFS_TRQ_FAC   8'h38
`define OFS_TRQ_SRC   8'h3C
`define OFS_OP_MODE   8'h40
`define OFS_TRQ_PCT   8'h44
`define OFS_CTRL      8'h48
`define OFS_CMD_VEL   8'h4C
`define OFS_IDX_CFG   8'h50
`define OFS_TGT_SPD   8'h54
`define OFS_MAX_TRQ   8'h58
`define OFS_STATUS    8'h5C
`define OFS_TABLE     8'h60
`define TABLE_IDX_LSB 2
// ----------------------------------------
// Field values
// ----------------------------------------
`define SRC_DIRECT    8'h00
`define SRC_CH1       8'h01
`define SRC_CH2       8'h02
`define MODE_INST_VEL 8'hFD
`define MODE_PROF_VEL 8'h03
`define MODE_TORQUE   8'h04
`define CTRL_ENABLE   16'h000F
`define CTRL_DISABLE  16'h0006
`define IDX_CFG_DIN_EN 4
`define VOLT_SCALE    32'sd100
`define RESET_ZERO    32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define MS_NS         1000000
`define FILT_FRAC     8
`endif

/* File: core/drive_cmd_pkg.sv */
// Purpose: Types shared by the command path modules
// Assumes: drive_cmd_map.svh holds offsets, field values and timing; APB state codes are here
// Notes:   State of each module is one packed struct
`include "drive_cmd_map.svh"
package drive_cmd_pkg;
    typedef enum logic [1:0] {
        APB_SETUP  = 2'b01,
        APB_ACCESS = 2'b10
    } apb_state_e;

    typedef struct packed {
        logic signed [24:0] acc;
        logic signed [15:0] cond;
    } cond_state_s;

    typedef struct packed {
        apb_state_e              apb;
        logic [31:0]             prdata;
        logic                    pslverr;
        logic [15:0]             tick_cnt;
        logic [15:0]             raw1, raw2, filt1, filt2, db1, db2, off1, off2;
        logic [15:0]             spd_fac, clamp_hi, clamp_lo, trq_fac, trq_pct, ctrl;
        logic [7:0]              spd_src, trq_src, op_mode;
        logic [31:0]             cmd_vel;
        logic [4:0]              idx_cfg;
        logic [7:0][31:0]        table_r;
        logic [31:0]             tgt_spd, max_trq;
        logic [15:0]             trq_cmd;
        logic                    spd_valid, prof, trq_lim, trq_mode, drv_en, din_mode;
    } cmd_state_s;
endpackage : drive_cmd_pkg

/* File: core/drive_speed_torque_command_path.sv */
// Purpose: Target speed, torque limit and torque command of the drive
// Assumes: Inputs synchronous to pclk; APB slave with no wait states
// Notes:   Outputs are registered; results lag index inputs by one cycle, analog inputs by four
`timescale 1ns/1ps
`include "drive_cmd_map.svh"
module drive_speed_torque_command_path
    import drive_cmd_pkg::*;
#(
    parameter int MS_TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog samples and index inputs
    input  wire logic [15:0] first_analog_channel,
    input  wire logic [15:0] second_analog_channel,
    input  wire logic        speed_index_bit_zero,
    input  wire logic        speed_index_bit_one,
    input  wire logic        speed_index_bit_two,
    // Toward the control loop
    output logic      [31:0] target_speed,
    output logic             speed_command_valid,
    output logic             profile_ramp_enable,
    output logic      [31:0] max_torque_limit,
    output logic             torque_limit_active,
    output logic      [15:0] torque_command,
    output logic             torque_mode_active,
    output logic             drive_enable
);
    cmd_state_s  st_r;
    cmd_state_s  st_nxt;
    logic [15:0] cond1;
    logic [15:0] cond2;
    logic        ms_tick;

    assign ms_tick = (st_r.tick_cnt == 16'(MS_TICK_CYCLES - 1));

    // ----------------------------------------
    // Channel conditioning
    // ----------------------------------------
    analog_conditioner u_cond1 (
        .pclk        (pclk),
        .presetn     (presetn),
        .ms_tick     (ms_tick),
        .raw_sample  (st_r.raw1),
        .offset      (st_r.off1),
        .deadband    (st_r.db1),
        .filter_time (st_r.filt1),
        .conditioned (cond1)
    );

    analog_conditioner u_cond2 (
        .pclk        (pclk),
        .presetn     (presetn),
        .ms_tick     (ms_tick),
        .raw_sample  (st_r.raw2),
        .offset      (st_r.off2),
        .deadband    (st_r.db2),
        .filter_time (st_r.filt2),
        .conditioned (cond2)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [31:0]        rd;
        logic               hit;
        logic               wr;
        logic signed [15:0] spd_v;
        logic signed [15:0] trq_v;
        logic               clamped;
        logic               din_avail;
        logic [2:0]         idx;
        logic signed [31:0] prod;
        rd        = `RESET_ZERO;
        hit       = 1'b1;
        wr        = 1'b0;
        spd_v     = 16'sh0000;
        trq_v     = 16'sh0000;
        clamped   = 1'b0;
        din_avail = 1'b0;
        idx       = 3'h0;
        prod      = 32'sh0000_0000;
        st_nxt    = st_r;

        // Millisecond divider for the filters
        st_nxt.tick_cnt = ms_tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;

        // Sample the converters every cycle
        st_nxt.raw1 = first_analog_channel;
        st_nxt.raw2 = second_analog_channel;

        // Read decode, done in setup so prdata is a flop
        case (paddr)
            `OFS_RAW1:     rd = {16'h0000, st_r.raw1};
            `OFS_COND1:    rd = {16'h0000, cond1};
            `OFS_RAW2:     rd = {16'h0000, st_r.raw2};
            `OFS_COND2:    rd = {16'h0000, cond2};
            `OFS_FILT1:    rd = {16'h0000, st_r.filt1};
            `OFS_DB1:      rd = {16'h0000, st_r.db1};
            `OFS_OFF1:     rd = {16'h0000, st_r.off1};
            `OFS_FILT2:    rd = {16'h0000, st_r.filt2};
            `OFS_DB2:      rd = {16'h0000, st_r.db2};
            `OFS_OFF2:     rd = {16'h0000, st_r.off2};
            `OFS_SPD_FAC:  rd = {16'h0000, st_r.spd_fac};
            `OFS_SPD_SRC:  rd = {24'h000000, st_r.spd_src};
            `OFS_CLAMP_HI: rd = {16'h0000, st_r.clamp_hi};
            `OFS_CLAMP_LO: rd = {16'h0000, st_r.clamp_lo};
            `OFS_TRQ_FAC:  rd = {16'h0000, st_r.trq_fac};
            `OFS_TRQ_SRC:  rd = {24'h000000, st_r.trq_src};
            `OFS_OP_MODE:  rd = {24'h000000, st_r.op_mode};
            `OFS_TRQ_PCT:  rd = {16'h0000, st_r.trq_pct};
            `OFS_CTRL:     rd = {16'h0000, st_r.ctrl};
            `OFS_CMD_VEL:  rd = st_r.cmd_vel;
            `OFS_IDX_CFG:  rd = {27'h0000000, st_r.idx_cfg};
            `OFS_TGT_SPD:  rd = st_r.tgt_spd;
            `OFS_MAX_TRQ:  rd = st_r.max_trq;
            `OFS_STATUS:   rd = {26'h0000000, st_r.din_mode, st_r.drv_en, st_r.trq_mode,
                                 st_r.trq_lim, st_r.prof, st_r.spd_valid};
            default: begin
                if (paddr[7:5] == `OFS_TABLE >> 5) begin
                    rd = st_r.table_r[paddr[4:2]];
                end else begin
                    rd  = `RESET_ZERO;
                    hit = 1'b0;
                end
            end
        endcase

        // APB handshake: answer in the cycle after setup
        case (st_r.apb)
            APB_SETUP: begin
                if (psel && !penable) begin
                    st_nxt.apb     = APB_ACCESS;
                    st_nxt.prdata  = pwrite ? `RESET_ZERO : rd;
                    st_nxt.pslverr = !hit;
                end
            end
            APB_ACCESS: begin
                wr             = psel && penable && pwrite && !st_r.pslverr;
                st_nxt.apb     = APB_SETUP;
                st_nxt.pslverr = 1'b0;
            end
            default: st_nxt.apb = APB_SETUP;
        endcase

        // Register writes take effect at completion
        if (wr) begin
            case (paddr)
                `OFS_FILT1:    st_nxt.filt1    = pwdata[15:0];
                `OFS_DB1:      st_nxt.db1      = pwdata[15:0];
                `OFS_OFF1:     st_nxt.off1     = pwdata[15:0];
                `OFS_FILT2:    st_nxt.filt2    = pwdata[15:0];
                `OFS_DB2:      st_nxt.db2      = pwdata[15:0];
                `OFS_OFF2:     st_nxt.off2     = pwdata[15:0];
                `OFS_SPD_FAC:  st_nxt.spd_fac  = pwdata[15:0];
                `OFS_SPD_SRC:  st_nxt.spd_src  = pwdata[7:0];
                `OFS_CLAMP_HI: st_nxt.clamp_hi = pwdata[15:0];
                `OFS_CLAMP_LO: st_nxt.clamp_lo = pwdata[15:0];
                `OFS_TRQ_FAC:  st_nxt.trq_fac  = pwdata[15:0];
                `OFS_TRQ_SRC:  st_nxt.trq_src  = pwdata[7:0];
                `OFS_OP_MODE:  st_nxt.op_mode  = pwdata[7:0];
                `OFS_TRQ_PCT:  st_nxt.trq_pct  = pwdata[15:0];
                `OFS_CTRL:     st_nxt.ctrl     = pwdata[15:0];
                `OFS_CMD_VEL:  st_nxt.cmd_vel  = pwdata;
                `OFS_IDX_CFG:  st_nxt.idx_cfg  = pwdata[4:0];
                default: begin
                    // Table entries; read-only and unmapped words ignore writes
                    for (int e = 0; e < 8; e++) begin
                        if (paddr == `OFS_TABLE + 8'(e << `TABLE_IDX_LSB)) begin
                            st_nxt.table_r[e] = pwdata;
                        end
                    end
                end
            endcase
        end

        // Digital index, unassigned bits forced to zero
        din_avail = |st_r.idx_cfg[2:0];
        idx = {speed_index_bit_two & st_r.idx_cfg[2],
               speed_index_bit_one & st_r.idx_cfg[1],
               speed_index_bit_zero & st_r.idx_cfg[0]};
        st_nxt.din_mode = din_avail && st_r.idx_cfg[`IDX_CFG_DIN_EN];

        // Speed path
        case (st_r.spd_src)
            `SRC_CH1: spd_v = $signed(cond1);
            `SRC_CH2: spd_v = $signed(cond2);
            default:  spd_v = 16'sh0000;
        endcase
        clamped = ((st_r.clamp_hi != 16'h0000) && (spd_v > $signed(st_r.clamp_hi))) ||
                  ((st_r.clamp_lo != 16'h0000) && (spd_v < $signed(st_r.clamp_lo)));
        if (st_r.spd_src == `SRC_CH1 || st_r.spd_src == `SRC_CH2) begin
            prod = 32'(spd_v * $signed(st_r.spd_fac)) / `VOLT_SCALE;
            st_nxt.tgt_spd = clamped ? `RESET_ZERO : prod;
        end else if (st_nxt.din_mode) begin
            st_nxt.tgt_spd = st_r.table_r[idx];
        end else begin
            st_nxt.tgt_spd = st_r.cmd_vel;
        end

        // Torque limit path
        case (st_r.trq_src)
            `SRC_CH1: trq_v = $signed(cond1);
            `SRC_CH2: trq_v = $signed(cond2);
            default:  trq_v = 16'sh0000;
        endcase
        st_nxt.trq_lim = (st_r.trq_src == `SRC_CH1) || (st_r.trq_src == `SRC_CH2);
        // Divide apart from the select; an unsigned arm would make the division unsigned
        prod = 32'(trq_v * $signed(st_r.trq_fac)) / `VOLT_SCALE;
        st_nxt.max_trq = st_nxt.trq_lim ? prod : `RESET_ZERO;

        // Operating mode decode
        st_nxt.spd_valid = (st_r.op_mode == `MODE_INST_VEL) || (st_r.op_mode == `MODE_PROF_VEL);
        st_nxt.prof      = (st_r.op_mode == `MODE_PROF_VEL);
        st_nxt.trq_mode  = (st_r.op_mode == `MODE_TORQUE);
        st_nxt.trq_cmd   = st_nxt.trq_mode ? st_r.trq_pct : 16'h0000;
        // Only the enable word runs the drive; 0x06 and all else stop it
        st_nxt.drv_en    = (st_r.ctrl == `CTRL_ENABLE);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= '0;
            st_r.apb <= APB_SETUP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign prdata              = st_r.prdata;
    assign pready              = (st_r.apb == APB_ACCESS);
    assign pslverr             = st_r.pslverr;
    assign target_speed        = st_r.tgt_spd;
    assign speed_command_valid = st_r.spd_valid;
    assign profile_ramp_enable = st_r.prof;
    assign max_torque_limit    = st_r.max_trq;
    assign torque_limit_active = st_r.trq_lim;
    assign torque_command      = st_r.trq_cmd;
    assign torque_mode_active  = st_r.trq_mode;
    assign drive_enable        = st_r.drv_en;
endmodule : drive_speed_torque_command_path

/* File: verif/cmd_path_assertions.sv */
// Purpose: Port checks of the speed and torque command path
// Assumes: APB answer one cycle after setup, outputs one edge behind registers
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`include "drive_cmd_map.svh"
module cmd_path_checker #(
    parameter int MS_TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Command outputs
    input wire logic [31:0] max_torque_limit,
    input wire logic        torque_limit_active,
    input wire logic [15:0] torque_command,
    input wire logic        torque_mode_active,
    input wire logic        speed_command_valid,
    input wire logic        profile_ramp_enable,
    input wire logic        drive_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bus steps
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    // Register write lands, output follows one edge later
    property p_mode_trq;
        logic [7:0] m;
        (s_wr(`OFS_OP_MODE), m = pwdata[7:0]) |-> ##2 torque_mode_active == (m == `MODE_TORQUE);
    endproperty
    property p_mode_vel;
        logic [7:0] m;
        (s_wr(`OFS_OP_MODE), m = pwdata[7:0]) |-> ##2 speed_command_valid == (m == `MODE_INST_VEL
            || m == `MODE_PROF_VEL) && profile_ramp_enable == (m == `MODE_PROF_VEL);
    endproperty
    property p_ctrl;
        logic e;
        (s_wr(`OFS_CTRL), e = pwdata[15:0] == `CTRL_ENABLE) |-> ##2 drive_enable == e;
    endproperty
    property p_trq_src;
        logic [7:0] v;
        (s_wr(`OFS_TRQ_SRC), v = pwdata[7:0]) |-> ##2 torque_limit_active == (v == 8'h01 || v == 8'h02);
    endproperty
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_apb_answer: assert property (s_setup |=> pready) else $error("no answer after setup");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
    chk_mode_torque: assert property (p_mode_trq) else $error("torque mode flag wrong");
    chk_mode_velocity: assert property (p_mode_vel) else $error("velocity mode flags wrong");
    chk_ctrl_enable: assert property (p_ctrl) else $error("drive enable wrong");
    chk_trq_source: assert property (p_trq_src) else $error("limit flag wrong");
    chk_trq_idle: assert property (!torque_mode_active |-> torque_command == 16'h0) else $error("torque leak");
    chk_limit_off: assert property (!torque_limit_active |-> max_torque_limit == 32'h0) else $error("limit leak");
    chk_prof_valid: assert property (profile_ramp_enable |-> speed_command_valid) else $error("ramp alone");
endmodule : cmd_path_checker
bind drive_speed_torque_command_path cmd_path_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) cmd_path_checker_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .max_torque_limit(max_torque_limit),
    .torque_limit_active(torque_limit_active), .torque_command(torque_command),
    .torque_mode_active(torque_mode_active), .speed_command_valid(speed_command_valid),
    .profile_ramp_enable(profile_ramp_enable), .drive_enable(drive_enable));

/* File: verif/control_loop_model.sv */
// Purpose: Velocity loop stand-in that consumes the speed command
// Assumes: Commands registered on pclk
// Notes:   Ramp is a fixed step per cycle, no real dynamics
`timescale 1ns/1ps
module control_loop_model #(
    parameter int RAMP_STEP = 50
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Commands
    input wire logic [31:0] target_speed,
    input wire logic        speed_command_valid,
    input wire logic        profile_ramp_enable,
    input wire logic        drive_enable,
    // Speed actually applied
    output logic     [31:0] applied_speed
);
    logic signed [31:0] d;
    assign d = $signed(target_speed) - $signed(applied_speed);
    // Disabled drive or invalid command drops to zero at once; ramp avoids a step in profile mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            applied_speed <= 32'h0;
        else if (!(drive_enable && speed_command_valid))
            applied_speed <= 32'h0;
        else if (!profile_ramp_enable || (d <= RAMP_STEP && d >= -RAMP_STEP))
            applied_speed <= target_speed;
        else if (d > 0)
            applied_speed <= applied_speed + RAMP_STEP;
        else
            applied_speed <= applied_speed - RAMP_STEP;
    end
endmodule : control_loop_model

/* File: verif/drive_speed_torque_command_path_test.sv */
// Purpose: Register and command checks of the speed and torque path
// Assumes: One millisecond shortened to 4 cycles
// Notes:   Filter is off except in one check so results settle in fixed cycles
`timescale 1ns/1ps
`include "drive_cmd_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module drive_speed_torque_command_path_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, target_speed, max_torque_limit, applied_speed;
    logic [15:0] ch1, ch2, torque_command;
    logic [2:0]  idx;
    logic        speed_command_valid, profile_ramp_enable, torque_limit_active, torque_mode_active, drive_enable;
    int          fails, checks_done, cyc;

    drive_speed_torque_command_path #(.MS_TICK_CYCLES(4)) drive_speed_torque_command_path_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_analog_channel(ch1), .second_analog_channel(ch2), .speed_index_bit_zero(idx[0]),
        .speed_index_bit_one(idx[1]), .speed_index_bit_two(idx[2]), .target_speed(target_speed),
        .speed_command_valid(speed_command_valid), .profile_ramp_enable(profile_ramp_enable),
        .max_torque_limit(max_torque_limit), .torque_limit_active(torque_limit_active),
        .torque_command(torque_command), .torque_mode_active(torque_mode_active), .drive_enable(drive_enable));
    control_loop_model control_loop_model_i (
        .pclk(pclk), .presetn(presetn), .target_speed(target_speed), .speed_command_valid(speed_command_valid),
        .profile_ramp_enable(profile_ramp_enable), .drive_enable(drive_enable), .applied_speed(applied_speed));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK(rdat, e)
    endtask : rd
    // Conditioned path needs three edges plus output register
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask : settle
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Hang guard, far above the few hundred cycles used
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ch1, ch2, idx} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 16; a <= 124; a += 4) rd(a[7:0], 32'h0);
        wr(`OFS_FILT1, 32'hFFFF_FFFF);
        rd(`OFS_FILT1, 32'h0000_FFFF);
        wr(`OFS_FILT1, 32'h0);
        wr(`OFS_SPD_SRC, 32'h1FF);
        rd(`OFS_SPD_SRC, 32'hFF);
        apb(8'h80, 1'b0, 32'h0);
        `CHK(perr, 1'b1)
        wr(`OFS_TGT_SPD, 32'h1234);
        rd(`OFS_TGT_SPD, 32'h0);
        $display("test registers done");
        wr(`OFS_OFF1, 32'd200);
        wr(`OFS_DB1, 32'd100);
        wr(`OFS_SPD_FAC, 32'd100);
        wr(`OFS_SPD_SRC, 32'd1);
        ch1 <= 16'd500;
        settle();
        `CHK(target_speed, 32'd200)
        rd(`OFS_RAW1, 32'd500);
        rd(`OFS_COND1, 32'd200);
        ch1 <= 16'hFE0C;
        settle();
        `CHK(target_speed, 32'hFFFF_FDA8)
        rd(`OFS_COND1, 32'h0000_FDA8);
        wr(`OFS_FILT1, 32'h8000);
        ch1 <= 16'd250;
        settle();
        `CHK(target_speed != 32'h0, 1'b1)
        wr(`OFS_FILT1, 32'h0);
        settle();
        `CHK(target_speed, 32'h0)
        $display("test analog speed done");
        ch1 <= 16'd500;
        wr(`OFS_CLAMP_HI, 32'd150);
        settle();
        `CHK(target_speed, 32'h0)
        wr(`OFS_CLAMP_HI, 32'd250);
        settle();
        `CHK(target_speed, 32'd200)
        wr(`OFS_CLAMP_HI, 32'h0);
        wr(`OFS_CLAMP_LO, 32'h0000_FF9C);
        ch1 <= 16'hFE0C;
        settle();
        `CHK(target_speed, 32'h0)
        wr(`OFS_CLAMP_LO, 32'h0);
        settle();
        `CHK(target_speed, 32'hFFFF_FDA8)
        $display("test clamp done");
        ch2 <= 16'd300;
        wr(`OFS_SPD_SRC, 32'd2);
        settle();
        `CHK(target_speed, 32'd300)
        wr(`OFS_TRQ_FAC, 32'd50);
        wr(`OFS_TRQ_SRC, 32'd1);
        settle();
        `CHK(max_torque_limit, 32'hFFFF_FED4)
        wr(`OFS_TRQ_SRC, 32'd2);
        settle();
        `CHK(max_torque_limit, 32'd150)
        wr(`OFS_TRQ_SRC, 32'd0);
        settle();
        `CHK(max_torque_limit, 32'h0)
        $display("test channel two done");
        wr(`OFS_SPD_SRC, 32'd0);
        wr(`OFS_CMD_VEL, 32'd1234);
        settle();
        `CHK(target_speed, 32'd1234)
        for (int i = 0; i < 8; i++) wr(`OFS_TABLE + 8'(4 * i), 32'(1000 + i));
        wr(`OFS_IDX_CFG, 32'h17);
        for (int i = 0; i < 8; i++) begin
            idx <= 3'(i);
            settle();
            `CHK(target_speed, 32'(1000 + i))
        end
        wr(`OFS_IDX_CFG, 32'h12);
        settle();
        `CHK(target_speed, 32'd1002)
        wr(`OFS_IDX_CFG, 32'h10);
        settle();
        `CHK(target_speed, 32'd1234)
        $display("test speed table done");
        wr(`OFS_OP_MODE, 32'h4);
        wr(`OFS_TRQ_PCT, 32'h0000_FFFB);
        settle();
        `CHK(torque_command, 16'hFFFB)
        wr(`OFS_OP_MODE, 32'hFD);
        wr(`OFS_CTRL, 32'h0F);
        settle();
        `CHK(torque_command, 16'h0)
        `CHK(applied_speed, 32'd1234)
        wr(`OFS_CTRL, 32'h06);
        settle();
        `CHK(applied_speed, 32'h0)
        wr(`OFS_OP_MODE, 32'h3);
        wr(`OFS_CTRL, 32'h0F);
        repeat (40) @(posedge pclk);
        `CHK({profile_ramp_enable, applied_speed}, {1'b1, 32'd1234})
        $display("test modes done");
        close_out();
    end
endmodule : drive_speed_torque_command_path_test
